// ---- logic/laps_codec_defines.vh ----
// Constants used by the LAPS frame codec module; byte_fifo does not include them.
`ifndef LAPS_CODEC_DEFINES_VH
`define LAPS_CODEC_DEFINES_VH
`define FLAG_OCTET 8'h7e
`define ESC_OCTET 8'h7d
`define ESC_XOR 8'h20
`define ESC_OF_FLAG 8'h5e
`define ESC_OF_ESC 8'h5d
`define ADAPT_OCTET 8'hdd
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'hedb88320
`define CRC_RESIDUE 32'hdebb20e3
`define SCR_LEN 43
`define SCR_TAP 42
`define MIN_OCTETS 4'h6
`define HDR_FIELDS 4'h4
`define MAC_ADDR_LAST 3'h5
`define FCS_LAST 3'h3
`define BIT_LAST 3'h7
`endif

// ---- logic/byte_fifo.v ----
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  // Fill side
  input wire [WIDTH-1:0] in_data_i,
  input wire in_valid_i,
  output reg in_ready_o,
  // Drain side
  output wire [WIDTH-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [31:0] LAST_W = DEPTH - 1;
  localparam [AW:0] FULL_CNT = DEPTH_W[AW:0];
  localparam [AW-1:0] LAST_PTR = LAST_W[AW-1:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr;
  reg [AW-1:0] rptr;
  reg [AW:0] count;
  reg [AW:0] next_count;
  wire push;
  wire pop;

  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always @(posedge ref_clk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wptr <= {AW{1'b0}};
      rptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready_o <= 1'b0;
    end else begin
      if (push) begin
        wptr <= (wptr == LAST_PTR) ? {AW{1'b0}} : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == LAST_PTR) ? {AW{1'b0}} : rptr + 1'b1;
      end
      count <= next_count;
      in_ready_o <= (next_count != FULL_CNT);
    end
  end
endmodule
`default_nettype wire

// ---- logic/laps_x86_frame_codec.v ----
// LAPS encapsulation and decapsulation over a sampled serial link.
`timescale 1ns/1ps
`default_nettype none
`include "laps_codec_defines.vh"
module laps_x86_frame_codec #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  // Configuration levels
  input wire tx_laps_enable_i,
  input wire scramble_enable_i,
  input wire descramble_enable_i,
  input wire [7:0] laps_address_value_i,
  input wire [7:0] laps_control_value_i,
  input wire [7:0] laps_sapi_high_value_i,
  input wire [7:0] laps_sapi_low_value_i,
  input wire [47:0] dest_addr_i,
  input wire [47:0] src_addr_i,
  // Transmit MAC frame stream
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  input wire tx_last_i,
  output wire tx_ready_o,
  // Transmit serial link
  input wire tx_clk_i,
  output reg tx_data_o,
  output reg tx_byte_strobe_o,
  // Receive serial link
  input wire rx_clk_i,
  input wire rx_data_i,
  input wire rx_byte_strobe_i,
  // Receive frame stream
  output reg [7:0] rx_data_o,
  output reg rx_valid_o,
  output reg rx_first_o,
  output reg rx_last_o,
  output reg rx_abort_o
);
  localparam T_IDLE = 4'h0;
  localparam T_ADDR = 4'h1;
  localparam T_CTRL = 4'h2;
  localparam T_SAPH = 4'h3;
  localparam T_SAPL = 4'h4;
  localparam T_DA = 4'h5;
  localparam T_SA = 4'h6;
  localparam T_PAY = 4'h7;
  localparam T_FCS = 4'h8;
  localparam R_HUNT = 1'b0;
  localparam R_FRAME = 1'b1;

  function [31:0] crc32_byte;
    input [31:0] crc;
    input [7:0] d;
    integer i;
    reg [31:0] c;
    begin
      c = crc ^ {24'h000000, d};
      for (i = 0; i < 8; i = i + 1) begin
        c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
      end
      crc32_byte = c;
    end
  endfunction

  function [7:0] addr_byte;
    input [47:0] a;
    input [2:0] i;
    begin
      case (i)
        3'h0: addr_byte = a[47:40];
        3'h1: addr_byte = a[39:32];
        3'h2: addr_byte = a[31:24];
        3'h3: addr_byte = a[23:16];
        3'h4: addr_byte = a[15:8];
        default: addr_byte = a[7:0];
      endcase
    end
  endfunction

  // Transmit byte buffer between the MAC stream and the frame builder.
  wire [8:0] f_data;
  wire f_valid;
  reg f_pop;
  byte_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_tx_fifo (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .in_data_i({tx_last_i, tx_data_i}),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop)
  );

  // Link signals pass two flip-flops; a third stage finds the edges.
  reg tck_s1, tck_s2, tck_s3;
  reg rck_s1, rck_s2, rck_s3;
  reg rdat_s1, rdat_s2;
  reg rstb_s1, rstb_s2;
  wire tx_rise = tck_s2 && !tck_s3;
  wire rx_fall = rck_s3 && !rck_s2;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tck_s1 <= 1'b0;
      tck_s2 <= 1'b0;
      tck_s3 <= 1'b0;
      rck_s1 <= 1'b0;
      rck_s2 <= 1'b0;
      rck_s3 <= 1'b0;
      rdat_s1 <= 1'b0;
      rdat_s2 <= 1'b0;
      rstb_s1 <= 1'b0;
      rstb_s2 <= 1'b0;
    end else begin
      tck_s1 <= tx_clk_i;
      tck_s2 <= tck_s1;
      tck_s3 <= tck_s2;
      rck_s1 <= rx_clk_i;
      rck_s2 <= rck_s1;
      rck_s3 <= rck_s2;
      rdat_s1 <= rx_data_i;
      rdat_s2 <= rdat_s1;
      rstb_s1 <= rx_byte_strobe_i;
      rstb_s2 <= rstb_s1;
    end
  end

  // Transmit frame builder, one octet per link octet slot.
  reg [3:0] tstate;
  reg [2:0] tidx;
  reg [31:0] tcrc;
  reg tesc;
  reg [7:0] tesc_byte;
  reg [7:0] tshift;
  reg [2:0] tbit;
  reg [`SCR_LEN-1:0] tscr;
  reg [3:0] next_tstate;
  reg [2:0] next_tidx;
  reg [7:0] raw;
  reg [7:0] oct;
  reg next_tesc;
  reg [7:0] next_tesc_byte;
  reg crc_en;
  reg adapt;
  wire tx_load = tx_rise && (tbit == 3'h0);
  wire [31:0] fcs = ~tcrc;
  reg tx_bit;
  reg tx_sbit;

  always @* begin
    next_tstate = tstate;
    next_tidx = tidx;
    raw = `FLAG_OCTET;
    crc_en = 1'b0;
    adapt = 1'b0;
    f_pop = 1'b0;
    case (tstate)
      T_IDLE: begin
        if (tx_laps_enable_i && f_valid) begin
          next_tstate = T_ADDR;
        end
      end
      T_ADDR: begin
        raw = laps_address_value_i;
        crc_en = 1'b1;
        next_tstate = T_CTRL;
      end
      T_CTRL: begin
        raw = laps_control_value_i;
        crc_en = 1'b1;
        next_tstate = T_SAPH;
      end
      T_SAPH: begin
        raw = laps_sapi_high_value_i;
        crc_en = 1'b1;
        next_tstate = T_SAPL;
      end
      T_SAPL: begin
        raw = laps_sapi_low_value_i;
        crc_en = 1'b1;
        next_tidx = 3'h0;
        next_tstate = T_DA;
      end
      T_DA, T_SA: begin
        raw = addr_byte((tstate == T_DA) ? dest_addr_i : src_addr_i,
                        tidx);
        crc_en = 1'b1;
        next_tidx = tidx + 1'b1;
        if (tidx == `MAC_ADDR_LAST) begin
          next_tidx = 3'h0;
          next_tstate = (tstate == T_DA) ? T_SA : T_PAY;
        end
      end
      T_PAY: begin
        if (f_valid) begin
          raw = f_data[7:0];
          crc_en = 1'b1;
          f_pop = tx_load && !tesc;
          if (f_data[8]) begin
            next_tstate = T_FCS;
          end
        end else begin
          adapt = 1'b1;
        end
      end
      T_FCS: begin
        case (tidx[1:0])
          2'h0: raw = fcs[7:0];
          2'h1: raw = fcs[15:8];
          2'h2: raw = fcs[23:16];
          default: raw = fcs[31:24];
        endcase
        next_tidx = tidx + 1'b1;
        if (tidx == `FCS_LAST) begin
          next_tstate = T_IDLE;
        end
      end
      default: begin
        next_tstate = T_IDLE;
      end
    endcase
    oct = raw;
    next_tesc = 1'b0;
    next_tesc_byte = tesc_byte;
    if (tesc) begin
      oct = tesc_byte;
      next_tstate = tstate;
      next_tidx = tidx;
      crc_en = 1'b0;
    end else if (adapt) begin
      oct = `ESC_OCTET;
      next_tesc = 1'b1;
      next_tesc_byte = `ADAPT_OCTET;
    end else if (tstate != T_IDLE &&
                 (raw == `FLAG_OCTET || raw == `ESC_OCTET)) begin
      oct = `ESC_OCTET;
      next_tesc = 1'b1;
      next_tesc_byte = raw ^ `ESC_XOR;
    end
  end

  always @* begin
    tx_bit = (tbit == 3'h0) ? oct[0] : tshift[tbit];
    tx_sbit = tx_bit ^ (scramble_enable_i && tscr[`SCR_TAP]);
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tstate <= T_IDLE;
      tidx <= 3'h0;
      tcrc <= `CRC_INIT;
      tesc <= 1'b0;
      tesc_byte <= 8'h00;
      tshift <= 8'h00;
      tbit <= 3'h0;
      tscr <= {`SCR_LEN{1'b0}};
      tx_data_o <= 1'b1;
      tx_byte_strobe_o <= 1'b0;
    end else if (tx_rise) begin
      tbit <= tbit + 1'b1;
      tscr <= {tscr[`SCR_LEN-2:0], tx_sbit};
      tx_data_o <= tx_laps_enable_i ? tx_sbit : 1'b1;
      tx_byte_strobe_o <= tx_laps_enable_i && (tbit == 3'h0);
      if (tbit == 3'h0) begin
        tshift <= oct;
        tstate <= next_tstate;
        tidx <= next_tidx;
        tesc <= next_tesc;
        tesc_byte <= next_tesc_byte;
        if (tstate == T_IDLE) begin
          tcrc <= `CRC_INIT;
        end else if (crc_en) begin
          tcrc <= crc32_byte(tcrc, raw);
        end
      end
    end
  end

  // Receive octet assembly after descrambling.
  reg [`SCR_LEN-1:0] rscr;
  reg [7:0] rsh;
  reg [2:0] rcnt;
  reg [7:0] rbyte;
  reg byte_done;
  wire rx_dbit = rdat_s2 ^ (descramble_enable_i && rscr[`SCR_TAP]);
  wire [7:0] next_rsh = {rx_dbit, rsh[7:1]};
  wire [2:0] cnt_now = rstb_s2 ? 3'h0 : rcnt;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rscr <= {`SCR_LEN{1'b0}};
      rsh <= 8'h00;
      rcnt <= 3'h0;
      rbyte <= 8'h00;
      byte_done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (rx_fall) begin
        rscr <= {rscr[`SCR_LEN-2:0], rdat_s2};
        rsh <= next_rsh;
        rcnt <= cnt_now + 1'b1;
        if (cnt_now == `BIT_LAST) begin
          rbyte <= next_rsh;
          byte_done <= 1'b1;
        end
      end
    end
  end

  // Receive frame checker; one octet is held back to mark the frame end.
  reg rstate;
  reg resc;
  reg [3:0] rlen;
  reg [31:0] rcrc;
  reg [7:0] hold;
  reg hfirst;
  reg [7:0] cbyte;
  reg [7:0] expect_byte;
  reg is_frame, r_accept, r_mism, r_abort, r_close, r_bad;
  reg esc_ok;

  always @* begin
    cbyte = resc ? (rbyte ^ `ESC_XOR) : rbyte;
    case (rlen[1:0])
      2'h0: expect_byte = laps_address_value_i;
      2'h1: expect_byte = laps_control_value_i;
      2'h2: expect_byte = laps_sapi_high_value_i;
      default: expect_byte = laps_sapi_low_value_i;
    endcase
    is_frame = byte_done && (rstate == R_FRAME);
    esc_ok = (rbyte == `ESC_OF_FLAG) || (rbyte == `ESC_OF_ESC);
    r_accept = is_frame && (resc ? esc_ok :
               (rbyte != `ESC_OCTET && rbyte != `FLAG_OCTET));
    r_mism = r_accept && (rlen < `HDR_FIELDS) &&
             (cbyte != expect_byte);
    r_accept = r_accept && !r_mism;
    r_abort = r_mism || (is_frame && resc && !esc_ok &&
              rbyte != `ADAPT_OCTET);
    r_close = is_frame && !resc && (rbyte == `FLAG_OCTET) &&
              (rlen != 4'h0);
    r_bad = (rlen < `MIN_OCTETS) || (rcrc != `CRC_RESIDUE);
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rstate <= R_HUNT;
      resc <= 1'b0;
      rlen <= 4'h0;
      rcrc <= `CRC_INIT;
      hold <= 8'h00;
      hfirst <= 1'b0;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_first_o <= 1'b0;
      rx_last_o <= 1'b0;
      rx_abort_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (byte_done && rstate == R_HUNT && rbyte == `FLAG_OCTET) begin
        rstate <= R_FRAME;
        resc <= 1'b0;
        rlen <= 4'h0;
        rcrc <= `CRC_INIT;
      end
      if (is_frame) begin
        resc <= !resc && (rbyte == `ESC_OCTET);
      end
      if (r_accept) begin
        rcrc <= crc32_byte(rcrc, cbyte);
        rlen <= (rlen == 4'hf) ? rlen : rlen + 1'b1;
        hold <= cbyte;
        hfirst <= (rlen == 4'h0);
        if (rlen != 4'h0) begin
          rx_valid_o <= 1'b1;
          rx_data_o <= hold;
          rx_first_o <= hfirst;
          rx_last_o <= 1'b0;
          rx_abort_o <= 1'b0;
        end
      end
      if (r_abort) begin
        rstate <= R_HUNT;
        rx_valid_o <= 1'b1;
        rx_data_o <= (rlen != 4'h0) ? hold : 8'h00;
        rx_first_o <= (rlen == 4'h0) || hfirst;
        rx_last_o <= 1'b1;
        rx_abort_o <= 1'b1;
      end
      if (r_close) begin
        rlen <= 4'h0;
        rcrc <= `CRC_INIT;
        rx_valid_o <= 1'b1;
        rx_data_o <= hold;
        rx_first_o <= hfirst;
        rx_last_o <= 1'b1;
        rx_abort_o <= r_bad;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/laps_codec_assertions.sv ----
// Concurrent checks on the ports of the LAPS frame codec.
`timescale 1ns/1ps
`default_nettype none
module laps_codec_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Watched ports
  input wire logic tx_laps_enable_i,
  input wire logic tx_data_o,
  input wire logic tx_byte_strobe_o,
  input wire logic rx_valid_o,
  input wire logic rx_first_o,
  input wire logic rx_last_o,
  input wire logic rx_abort_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  logic strb_q;
  logic in_frame;
  logic [7:0] gap;
  wire strb_rise = tx_byte_strobe_o && !strb_q;
  // The gap count restarts whenever the transmitter is switched off.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strb_q <= 1'b0;
      gap <= 8'h00;
      in_frame <= 1'b0;
    end else begin
      strb_q <= tx_byte_strobe_o;
      if (!tx_laps_enable_i) begin
        gap <= 8'h00;
      end else if (strb_rise) begin
        gap <= 8'h01;
      end else if (gap != 8'h00 && gap != 8'hff) begin
        gap <= gap + 8'h01;
      end
      if (rx_valid_o) begin
        in_frame <= !rx_last_o;
      end
    end
  end
  sequence strobe_bit;
    tx_byte_strobe_o [*8] ##[1:8] !tx_byte_strobe_o;
  endsequence
  sequence quiet8;
    !rx_valid_o [*8];
  endsequence
  a_laps_off_idle: assert property (!tx_laps_enable_i [*4] |->
    tx_data_o && !tx_byte_strobe_o) else $error("line not idle");
  a_strobe_width: assert property ($rose(tx_byte_strobe_o) |->
    strobe_bit) else $error("strobe not one bit long");
  a_strobe_period: assert property (strb_rise && gap != 8'h00 |->
    gap >= 8'h60 && gap <= 8'h68) else $error("strobe not every octet");
  a_bit_hold: assert property ($changed(tx_data_o) &&
    tx_laps_enable_i && $past(tx_laps_enable_i, 30) |=>
    $stable(tx_data_o) [*8]) else $error("tx bit shorter than link bit");
  a_valid_pulse: assert property (rx_valid_o |=> quiet8)
    else $error("rx bytes too close");
  a_abort_on_last: assert property (rx_valid_o && rx_abort_o |->
    rx_last_o) else $error("abort without frame end");
  a_short_abort: assert property (rx_valid_o && rx_first_o &&
    rx_last_o |-> rx_abort_o) else $error("one byte frame kept");
  a_frame_opens: assert property (rx_valid_o && !in_frame |->
    rx_first_o) else $error("frame without start mark");
endmodule
`default_nettype wire

// ---- dv/link_partner.sv ----
// Far-end link model: free-running link clock, loopback or fixed octets.
`timescale 1ns/1ps
`default_nettype none
module link_partner (
  // Link from the codec, plus the bench flip and inject controls
  input wire logic tx_data_i,
  input wire logic tx_byte_strobe_i,
  input wire logic flip_i,
  input wire logic inj_i,
  // Link to the codec
  output logic link_clk_o,
  output logic rx_data_o,
  output logic rx_byte_strobe_o
);
  initial begin
    link_clk_o = 1'b0;
    rx_data_o = 1'b1;
    rx_byte_strobe_o = 1'b0;
    forever #62.5 link_clk_o = ~link_clk_o;
  end
  // Bits change on the rising link edge so they are steady at the fall.
  // A raised flip input corrupts the returned bit on command.
  // While inject is high a fixed unscrambled octet list replaces the
  // loopback; it holds bad header, abort, short and bad escape frames.
  logic [7:0] seq [18] = '{8'h7e, 8'h7e, 8'h7e, 8'h00, 8'h03, 8'h7e,
    8'hc3, 8'h03, 8'h7d, 8'h7e, 8'h7e, 8'hc3, 8'h03, 8'h7e, 8'hc3,
    8'h7d, 8'h11, 8'h7e};
  int pos = 0;
  int bitn = 0;
  always @(posedge link_clk_o) begin
    if (inj_i) begin
      rx_data_o <= seq[pos][bitn];
      rx_byte_strobe_o <= (bitn == 0);
      bitn <= (bitn == 7) ? 0 : bitn + 1;
      if (bitn == 7 && pos < 17) pos <= pos + 1;
    end else begin
      pos <= 0;
      bitn <= 0;
      rx_data_o <= tx_data_i ^ flip_i;
      rx_byte_strobe_o <= tx_byte_strobe_i;
    end
  end
endmodule
`default_nettype wire

// ---- dv/laps_x86_frame_codec_tb.sv ----
// Loopback bench for the LAPS frame codec.
`timescale 1ns/1ps
`default_nettype none
module laps_x86_frame_codec_tb;
  typedef struct {
    logic [7:0] fill;
    int len;
    int gap;
    bit flip;
    logic abort;
  } row_t;
  row_t rows [4];
  logic ref_clk_i, nrst_i, ena, flip, lclk, lrx, lrxs, tser, tstb;
  logic tx_valid, tx_last, tx_ready, rx_valid, rx_first, rx_last, rx_abort;
  logic [7:0] tx_data, rx_data, adr, ctl, sph, spl;
  logic [47:0] da, sa;
  logic inj;
  logic [10:0] inj_exp [6] = '{11'h007, 11'h61c, 11'h01b, 11'h61c,
    11'h01b, 11'h61f};
  int t;
  int n_fail, checked;
  bit full;
  laps_x86_frame_codec dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .tx_laps_enable_i(ena),
    .scramble_enable_i(ena), .descramble_enable_i(ena && !inj),
    .laps_address_value_i(adr), .laps_control_value_i(ctl),
    .laps_sapi_high_value_i(sph), .laps_sapi_low_value_i(spl),
    .dest_addr_i(da), .src_addr_i(sa), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_last_i(tx_last), .tx_ready_o(tx_ready),
    .tx_clk_i(lclk), .tx_data_o(tser), .tx_byte_strobe_o(tstb),
    .rx_clk_i(lclk), .rx_data_i(lrx), .rx_byte_strobe_i(lrxs),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_first_o(rx_first),
    .rx_last_o(rx_last), .rx_abort_o(rx_abort));
  link_partner far (.tx_data_i(tser), .tx_byte_strobe_i(tstb),
    .flip_i(flip), .inj_i(inj), .link_clk_o(lclk), .rx_data_o(lrx),
    .rx_byte_strobe_o(lrxs));
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Each byte is held until ready is seen high before a rising edge.
  task automatic send_frame(input row_t r);
    logic ok;
    int i, t;
    for (i = 0; i < r.len; i++) begin
      tx_data <= r.fill;
      tx_last <= (i == r.len - 1);
      tx_valid <= 1'b1;
      t = 0;
      do begin
        @(negedge ref_clk_i);
        ok = tx_ready;
        if (ok !== 1'b1) full = 1'b1;
        @(posedge ref_clk_i);
        t++;
      end while (ok !== 1'b1 && t < 3000);
      if (ok !== 1'b1) begin
        n_fail++;
        results();
      end
      if (r.gap > 0) begin
        tx_valid <= 1'b0;
        tick(r.gap);
      end
    end
    tx_valid <= 1'b0;
  endtask
  task automatic collect(input row_t r);
    int n, t;
    logic done;
    n = 0;
    t = 0;
    done = 1'b0;
    while (!done && t < 40000) begin
      @(negedge ref_clk_i);
      t++;
      if (rx_valid === 1'b1 && (n > 0 || rx_first === 1'b1)) begin
        if (n == 0) check("address", rx_data, adr);
        if (n == 3) check("sapi low", rx_data, spl);
        if (n == 4) check("dest", rx_data, da[47:40]);
        if (n == 10) check("src", rx_data, sa[47:40]);
        if (n >= 16 && n < 16 + r.len && !r.flip)
          check("payload", rx_data, r.fill);
        n++;
        done = (rx_last === 1'b1);
      end
    end
    if (!done) begin
      n_fail++;
      results();
    end
    check("abort", {7'h00, rx_abort}, {7'h00, r.abort});
    if (!r.flip) check("length", n[7:0], 8'(20 + r.len));
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    rows = '{'{8'h11, 3, 0, 1'b0, 1'b0}, '{8'h7e, 2, 3000, 1'b0, 1'b0},
      '{8'h7d, 12, 0, 1'b0, 1'b0}, '{8'h5a, 6, 0, 1'b1, 1'b1}};
    {nrst_i, ena, flip, inj, tx_valid, tx_last} = 6'h00;
    tx_data = 8'h00;
    adr = 8'hc3;
    ctl = 8'h03;
    sph = 8'h7d;
    spl = 8'h01;
    da = 48'h0a0b0c0d0e0f;
    sa = 48'h7e7d01020304;
    n_fail = 0;
    checked = 0;
    full = 1'b0;
    tick(20);
    nrst_i <= 1'b1;
    repeat (3) begin
      tick(100);
      @(negedge ref_clk_i);
      check("idle line", {6'h00, tser, tstb}, 8'h02);
    end
    tick(1);
    ena <= 1'b1;
    tick(3000);
    for (int k = 0; k < 4; k++) begin
      fork
        send_frame(rows[k]);
        collect(rows[k]);
        if (rows[k].flip) begin
          tick(1200);
          flip <= 1'b1;
          tick(13);
          flip <= 1'b0;
        end
      join
      if (k == 2) check("fifo refused", {7'h00, full}, 8'h01);
      tick(1);
    end
    // Fixed octets with descrambling off; early outputs are flushed junk.
    inj <= 1'b1;
    tick(300);
    for (int j = 0; j < 6; j++) begin
      t = 0;
      do begin
        @(negedge ref_clk_i);
        t++;
      end while (rx_valid !== 1'b1 && t < 1000);
      if (rx_valid !== 1'b1) begin
        n_fail++;
        results();
      end
      check("inject data", rx_data, inj_exp[j][10:3]);
      check("inject flags", {5'h00, rx_first, rx_last, rx_abort},
            {5'h00, inj_exp[j][2:0]});
    end
    tick(10);
    inj <= 1'b0;
    nrst_i <= 1'b0;
    tick(2);
    @(negedge ref_clk_i);
    check("reset outputs", {4'h0, tser, tstb, rx_valid, tx_ready},
          8'h08);
    tick(1);
    nrst_i <= 1'b1;
    tick(2);
    @(negedge ref_clk_i);
    check("ready", {7'h00, tx_ready}, 8'h01);
    results();
  end
endmodule
bind laps_x86_frame_codec laps_codec_checker chk (.ref_clk_i(ref_clk_i),
  .nrst_i(nrst_i), .tx_laps_enable_i(tx_laps_enable_i),
  .tx_data_o(tx_data_o), .tx_byte_strobe_o(tx_byte_strobe_o),
  .rx_valid_o(rx_valid_o), .rx_first_o(rx_first_o),
  .rx_last_o(rx_last_o), .rx_abort_o(rx_abort_o));
`default_nettype wire
